// *** dv/testbench.sv ***
`timescale 1ns/1ps
//======================================================================
// self-checking bench of the loop and pin configuration block
module testbench;
    import tlpc_pkg::*;
    logic           clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]     reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic           lowpower_pin_i = 1'b0, tx_disable_pin_i = 1'b0, tx_fault_i = 1'b0;
    logic           signal_detect_i = 1'b0, tx_detect_i = 1'b0, analog_out_i = 1'b0;
    logic           pd_ctrl_i = 1'b0, loop_tick_i = 1'b0, conv_active_i = 1'b0;
    logic [7:0]     rx_power_sample_i = 8'h00;
    tlpc_cal_pair_t lower_pair_i = 16'h0000, upper_pair_i = 16'h0000, rx_cal_pair_o;
    logic           ext_sensor_sel_o, sensor_power_o, loop_running_o, track_table_use_o;
    logic [5:0]     temp_trim_o;
    tlpc_loop_req_t loop_req_o;
    logic           rx_power_down_o, tx_power_down_o, pin39_o, pin21_o, nosig_pin_o;
    logic           pd_ctrl_o, pd_ctrl_oe_o, tx_data_en_o, laser_current_en_o;
    logic           soft_tx_fault_o, tx_disable_eff_o, rd_seen = 1'b0;
    int             failures = 0, checks = 0, seed = 32'h2953FD94;
    logic [7:0]     exp_q[$], c[9], lcfg;
    logic [15:0]    el;
    localparam logic [7:0] ADR [9] = '{8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBE, 8'hBF,
                                        8'hC0, 8'hC1};
    localparam logic [7:0] MSK [9] = '{8'hE0, 8'hDD, 8'h11, 8'h3F, 8'hFF, 8'h7F, 8'h0F,
                                        8'h01, 8'h20};
    localparam logic [7:0] RST [9] = '{8'h60, 8'hDC, 8'h00, 8'h1F, 8'hFF, 8'h40, 8'h0B,
                                        8'h00, 8'h20};

    //==================================================================
    // clock and device
    always #4 clk_i = ~clk_i;
    tlpc_top u_dut (.*);

    //==================================================================
    // comparisons and verdict
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_out(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_out
    task automatic results();
        if (exp_q.size() != 0) failures++;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // read monitor: oldest note against data one cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen && exp_q.size() > 0) cmp_rd(reg_rdata_o, exp_q.pop_front());
        rd_seen <= reg_rd_i;
    end

    //==================================================================
    // register bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
    endtask : rd

    // pin and control outputs against the register image
    task automatic chk_pins();
        logic        fd;
        logic [15:0] ep;
        logic [15:0] gp;
        fd = tx_fault_i ^ c[5][4];
        // loop stays quiet while disabled, whatever the tick does
        ep = 16'({4'h0, c[5][6] ? analog_out_i : fd, c[5][5] ? (tx_detect_i | ~c[6][2]) : fd,
                  c[6][1] | ~(signal_detect_i ^ c[5][3]), ~c[6][3], ~c[6][0], ~c[6][0],
                  c[7][0], tx_disable_pin_i ^ c[5][0]});
        gp = 16'({loop_req_o, pin39_o, pin21_o, nosig_pin_o, pd_ctrl_oe_o, tx_data_en_o,
                  laser_current_en_o, soft_tx_fault_o, tx_disable_eff_o});
        cmp_out(gp, ep);
        gp = 16'({pd_ctrl_o, rx_power_down_o, tx_power_down_o, ext_sensor_sel_o,
                  sensor_power_o, track_table_use_o, loop_running_o, temp_trim_o});
        ep = 16'({pd_ctrl_i, c[2][4] & lowpower_pin_i, c[2][0] & lowpower_pin_i, c[0][7],
                  (c[8][5] & c[0][5]) | conv_active_i, c[1][4], c[1][0], c[3][5:0]});
        cmp_out(gp, ep);
        gp = rx_cal_pair_o;
        ep = (rx_power_sample_i > c[4]) ? upper_pair_i : lower_pair_i;
        cmp_out(gp, ep);
    endtask : chk_pins

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        results();
    end

    //==================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        c = RST;
        // reset values, unmapped place
        for (int i = 0; i < 9; i++) rd(ADR[i], RST[i]);
        rd(8'hBB, 8'h00);
        wr(8'hBC, 8'hFF);
        rd(8'hBC, 8'h00);
        chk_pins();
        // random configurations and pin levels
        for (int n = 0; n < 24; n++) begin
            for (int i = 0; i < 9; i++) begin
                c[i] = 8'($random(seed));
                if (i == 1) c[i][0] = 1'b0;
                wr(ADR[i], c[i]);
                c[i] = c[i] & MSK[i];
            end
            for (int i = 0; i < 9; i++) rd(ADR[i], c[i]);
            @(posedge clk_i);
            {lowpower_pin_i, tx_disable_pin_i, tx_fault_i, signal_detect_i, tx_detect_i,
             analog_out_i, pd_ctrl_i, conv_active_i, loop_tick_i} <= 9'($random(seed));
            rx_power_sample_i <= n[0] ? 8'($random(seed)) : c[4];
            lower_pair_i      <= 16'($random(seed));
            upper_pair_i      <= 16'($random(seed));
            repeat (5) @(posedge clk_i);
            chk_pins();
        end
        loop_tick_i <= 1'b0;
        // loop iterations with all and some steps enabled
        for (int p = 0; p < 2; p++) begin
            lcfg = p[0] ? 8'h85 : 8'hDD;
            wr(8'hB7, lcfg);
            @(posedge clk_i);
            loop_tick_i <= 1'b1;
            @(posedge clk_i);
            loop_tick_i <= 1'b0;
            for (int k = 1; k <= 6; k++) begin
                @(posedge clk_i);
                el = (k > 4) ? 16'h0000 : 16'({lcfg[7], lcfg[2], lcfg[3], lcfg[6]}
                                              & (4'b1000 >> (k - 1)));
                cmp_out(16'(loop_req_o), el);
            end
            rd(8'hB7, lcfg);
        end
        repeat (3) @(posedge clk_i);
        results();
    end
endmodule : testbench

// *** dv/tlpc_assertions.sv ***
`timescale 1ns/1ps
//======================================================================
// port-level checks of the loop and pin configuration block
module tlpc_assertions
    import tlpc_pkg::*;
(
    // clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // register access
    input  wire logic           reg_rd_i,
    input  wire logic [7:0]     reg_addr_i,
    input  wire logic [7:0]     reg_rdata_o,
    // status inputs
    input  wire logic           lowpower_pin_i,
    input  wire logic           pd_ctrl_i,
    input  wire logic           loop_tick_i,
    input  wire logic           conv_active_i,
    input  wire logic [7:0]     rx_power_sample_i,
    input  wire tlpc_cal_pair_t lower_pair_i,
    // observed outputs
    input  wire tlpc_cal_pair_t rx_cal_pair_o,
    input  wire logic           ext_sensor_sel_o,
    input  wire logic           sensor_power_o,
    input  wire logic           loop_running_o,
    input  wire tlpc_loop_req_t loop_req_o,
    input  wire logic           rx_power_down_o,
    input  wire logic           pd_ctrl_o,
    input  wire logic           pd_ctrl_oe_o,
    input  wire logic           tx_data_en_o,
    input  wire logic           laser_current_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // register images and the unmapped address against read data
    a_ext_sensor_image: assert property (
        reg_rd_i && reg_addr_i == TLPC_OFF_TEMP_CFG |=> reg_rdata_o[7] == ext_sensor_sel_o)
        else $error("sensor select differs from register");
    a_loop_en_image: assert property (
        reg_rd_i && reg_addr_i == TLPC_OFF_LOOP_CFG |=> reg_rdata_o[0] == loop_running_o)
        else $error("loop running differs from register");
    a_unmapped_read_zero: assert property (
        reg_rd_i && reg_addr_i == 8'hBB |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // loop step timing after a tick
    a_bias_spacing: assert property (
        loop_req_o.bias_load |=> !loop_req_o.bias_load [*5])
        else $error("bias load repeated too soon");
    a_mod_after_tick: assert property (loop_req_o.mod_load |-> $past(loop_tick_i, 2))
        else $error("modulation load without tick");
    a_mon_after_tick: assert property (loop_req_o.mon_recalc |-> $past(loop_tick_i, 4))
        else $error("monitor recalc without tick");
    // pin and power relations
    a_low_sample_lower: assert property (
        rx_power_sample_i == 8'h00 |-> rx_cal_pair_o == lower_pair_i)
        else $error("zero sample picked upper pair");
    a_rx_down_sync: assert property (rx_power_down_o |-> $past(lowpower_pin_i, 2))
        else $error("receive power down without pin");
    a_sensor_conv_power: assert property (conv_active_i |-> sensor_power_o)
        else $error("sensor off during conversion");
    a_laser_pair: assert property (tx_data_en_o == laser_current_en_o)
        else $error("data and laser enables differ");
    a_pd_follow: assert property (pd_ctrl_oe_o |-> pd_ctrl_o == $past(pd_ctrl_i))
        else $error("driven photodiode output wrong");

    // main scenarios reached
    c_bias_step: cover property (loop_req_o.bias_load);
    c_rx_down: cover property (rx_power_down_o);
    c_pd_drive: cover property (pd_ctrl_oe_o && pd_ctrl_o);
endmodule : tlpc_assertions

bind tlpc_top tlpc_assertions u_chk (.clk_i, .rst_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
    .lowpower_pin_i, .pd_ctrl_i, .loop_tick_i, .conv_active_i, .rx_power_sample_i,
    .lower_pair_i, .rx_cal_pair_o, .ext_sensor_sel_o, .sensor_power_o, .loop_running_o,
    .loop_req_o, .rx_power_down_o, .pd_ctrl_o, .pd_ctrl_oe_o, .tx_data_en_o,
    .laser_current_en_o);

// *** hw/tlpc_regfile.sv ***
`timescale 1ns/1ps
//======================================================================
// configuration register storage with masked writes and registered read
module tlpc_regfile
    import tlpc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // access request
    input  wire tlpc_req_t  req_i,
    // read data and register images
    output logic [7:0]      rdata_o,
    output logic [7:0]      temp_cfg_o,
    output logic [7:0]      loop_cfg_o,
    output logic [7:0]      lp_cfg_o,
    output logic [7:0]      trim_o,
    output logic [7:0]      rxp_thr_o,
    output logic [7:0]      pin_func_o,
    output logic [7:0]      quiet_o,
    output logic [7:0]      inj_fault_o,
    output logic [7:0]      temp_pwr_o
);

    // masked merge of a write
    function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] wm);
        merge = wd & wm;
    endfunction : merge

    // address hits
    wire hit_temp  = (req_i.addr == TLPC_OFF_TEMP_CFG);
    wire hit_loop  = (req_i.addr == TLPC_OFF_LOOP_CFG);
    wire hit_lp    = (req_i.addr == TLPC_OFF_LP_CFG);
    wire hit_trim  = (req_i.addr == TLPC_OFF_TRIM);
    wire hit_thr   = (req_i.addr == TLPC_OFF_RXP_THR);
    wire hit_pin   = (req_i.addr == TLPC_OFF_PIN_FUNC);
    wire hit_quiet = (req_i.addr == TLPC_OFF_QUIET);
    wire hit_inj   = (req_i.addr == TLPC_OFF_INJ_FAULT);
    wire hit_tpwr  = (req_i.addr == TLPC_OFF_TEMP_PWR);

    // read selection, undefined bits and addresses read zero
    logic [7:0] rd_sel;
    assign rd_sel = hit_temp  ? temp_cfg_o  :
                    hit_loop  ? loop_cfg_o  :
                    hit_lp    ? lp_cfg_o    :
                    hit_trim  ? trim_o      :
                    hit_thr   ? rxp_thr_o   :
                    hit_pin   ? pin_func_o  :
                    hit_quiet ? quiet_o     :
                    hit_inj   ? inj_fault_o :
                    hit_tpwr  ? temp_pwr_o  : 8'h00;

    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_cfg_o  <= TLPC_RST_TEMP_CFG;
            loop_cfg_o  <= TLPC_RST_LOOP_CFG;
            lp_cfg_o    <= TLPC_RST_LP_CFG;
            trim_o      <= TLPC_RST_TRIM;
            rxp_thr_o   <= TLPC_RST_RXP_THR;
            pin_func_o  <= TLPC_RST_PIN_FUNC;
            quiet_o     <= TLPC_RST_QUIET;
            inj_fault_o <= TLPC_RST_INJ_FAULT;
            temp_pwr_o  <= TLPC_RST_TEMP_PWR;
        end else if (req_i.wr) begin
            if (hit_temp)  temp_cfg_o  <= merge(req_i.wdata, TLPC_WM_TEMP_CFG);
            if (hit_loop)  loop_cfg_o  <= merge(req_i.wdata, TLPC_WM_LOOP_CFG);
            if (hit_lp)    lp_cfg_o    <= merge(req_i.wdata, TLPC_WM_LP_CFG);
            if (hit_trim)  trim_o      <= merge(req_i.wdata, TLPC_WM_TRIM);
            if (hit_thr)   rxp_thr_o   <= merge(req_i.wdata, TLPC_WM_RXP_THR);
            if (hit_pin)   pin_func_o  <= merge(req_i.wdata, TLPC_WM_PIN_FUNC);
            if (hit_quiet) quiet_o     <= merge(req_i.wdata, TLPC_WM_QUIET);
            if (hit_inj)   inj_fault_o <= merge(req_i.wdata, TLPC_WM_INJ_FAULT);
            if (hit_tpwr)  temp_pwr_o  <= merge(req_i.wdata, TLPC_WM_TEMP_PWR);
        end
    end

    // registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            rdata_o <= rd_sel;
        end
    end

endmodule : tlpc_regfile

// *** hw/tlpc_top.sv ***
`timescale 1ns/1ps
//======================================================================
// loop and pin configuration block of the transceiver controller
module tlpc_top
    import tlpc_pkg::*;
(
    // clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // two-wire port register access
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    input  wire logic [7:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    output logic [7:0]          reg_rdata_o,
    // pins from outside
    input  wire logic           lowpower_pin_i,
    input  wire logic           tx_disable_pin_i,
    // internal status from analog side
    input  wire logic           tx_fault_i,
    input  wire logic           signal_detect_i,
    input  wire logic           tx_detect_i,
    input  wire logic           analog_out_i,
    input  wire logic           pd_ctrl_i,
    input  wire logic           loop_tick_i,
    input  wire logic           conv_active_i,
    // receive power calibration
    input  wire logic [7:0]     rx_power_sample_i,
    input  wire tlpc_cal_pair_t lower_pair_i,
    input  wire tlpc_cal_pair_t upper_pair_i,
    output tlpc_cal_pair_t      rx_cal_pair_o,
    // temperature sensor control
    output logic                ext_sensor_sel_o,
    output logic                sensor_power_o,
    output logic [5:0]          temp_trim_o,
    // loop control
    output logic                loop_running_o,
    output tlpc_loop_req_t      loop_req_o,
    output logic                track_table_use_o,
    // path power
    output logic                rx_power_down_o,
    output logic                tx_power_down_o,
    // output pins
    output logic                pin39_o,
    output logic                pin21_o,
    output logic                nosig_pin_o,
    output logic                pd_ctrl_o,
    output logic                pd_ctrl_oe_o,
    output logic                tx_data_en_o,
    output logic                laser_current_en_o,
    // laser safety outputs
    output logic                soft_tx_fault_o,
    output logic                tx_disable_eff_o
);

    //==================================================================
    // register bank
    tlpc_req_t  req;
    logic [7:0] temp_cfg;
    logic [7:0] loop_cfg;
    logic [7:0] lp_cfg;
    logic [7:0] trim;
    logic [7:0] rxp_thr;
    logic [7:0] pin_func;
    logic [7:0] quiet;
    logic [7:0] inj_fault;
    logic [7:0] temp_pwr;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

    tlpc_regfile u_regs (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .req_i       (req),
        .rdata_o     (reg_rdata_o),
        .temp_cfg_o  (temp_cfg),
        .loop_cfg_o  (loop_cfg),
        .lp_cfg_o    (lp_cfg),
        .trim_o      (trim),
        .rxp_thr_o   (rxp_thr),
        .pin_func_o  (pin_func),
        .quiet_o     (quiet),
        .inj_fault_o (inj_fault),
        .temp_pwr_o  (temp_pwr)
    );

    //==================================================================
    // pin synchronisers
    logic lp_meta;
    logic lp_sync;
    logic dis_meta;
    logic dis_sync;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_meta  <= 1'b0;
            lp_sync  <= 1'b0;
            dis_meta <= 1'b0;
            dis_sync <= 1'b0;
        end else begin
            lp_meta  <= lowpower_pin_i;
            lp_sync  <= lp_meta;
            dis_meta <= tx_disable_pin_i;
            dis_sync <= dis_meta;
        end
    end

    //==================================================================
    // temperature sensor control
    wire power_keep = temp_cfg[TLPC_B_POWER_KEEP];
    wire power_hold = temp_pwr[TLPC_B_POWER_HOLD];

    assign ext_sensor_sel_o = temp_cfg[TLPC_B_EXT_SENSOR];
    // powered always when both hold and keep bits are set, else only during conversions
    assign sensor_power_o   = (power_hold & power_keep) | conv_active_i;
    assign temp_trim_o      = trim[5:0];

    //==================================================================
    // receive power calibration pair selection
    wire rxp_upper = (rx_power_sample_i > rxp_thr);
    assign rx_cal_pair_o = rxp_upper ? upper_pair_i : lower_pair_i;

    //==================================================================
    // low-power pin response
    assign rx_power_down_o = lp_cfg[TLPC_B_RX_FOLLOW] & lp_sync;
    assign tx_power_down_o = lp_cfg[TLPC_B_TX_FOLLOW] & lp_sync;

    //==================================================================
    // main loop sequencer, one pass of enabled steps per tick
    tlpc_state_t state;
    tlpc_state_t next_state;
    wire loop_en = loop_cfg[TLPC_B_LOOP_EN];
    wire en_bias = loop_cfg[TLPC_B_BIAS_TBL];
    wire en_mod  = loop_cfg[TLPC_B_MOD_TBL];
    wire en_pd   = loop_cfg[TLPC_B_PD_TBL];
    wire en_mon  = loop_cfg[TLPC_B_MON_RECALC];

    always_comb begin
        next_state = state;
        case (state)
            TLPC_S_IDLE: if (loop_en && loop_tick_i) next_state = TLPC_S_BIAS;
            TLPC_S_BIAS: next_state = TLPC_S_MOD;
            TLPC_S_MOD:  next_state = TLPC_S_PD;
            TLPC_S_PD:   next_state = TLPC_S_MON;
            TLPC_S_MON:  next_state = TLPC_S_DONE;
            TLPC_S_DONE: next_state = TLPC_S_IDLE;
            default:     next_state = TLPC_S_IDLE;
        endcase
        if (!loop_en) next_state = TLPC_S_IDLE;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) state <= TLPC_S_IDLE;
        else       state <= next_state;
    end

    // load strobes, one per iteration for each enabled step
    tlpc_loop_req_t next_req;
    always_comb begin
        next_req            = '0;
        next_req.bias_load  = (state == TLPC_S_BIAS) & en_bias & loop_en;
        next_req.mod_load   = (state == TLPC_S_MOD)  & en_mod  & loop_en;
        next_req.pd_load    = (state == TLPC_S_PD)   & en_pd   & loop_en;
        next_req.mon_recalc = (state == TLPC_S_MON)  & en_mon  & loop_en;
    end

    assign loop_req_o        = next_req;
    assign loop_running_o    = loop_en;
    assign track_table_use_o = loop_cfg[TLPC_B_TRACK_TBL];

    //==================================================================
    // output pin shaping
    wire fault_drv   = tx_fault_i ^ pin_func[TLPC_B_FAULT_INV];
    wire detect_drv  = quiet[TLPC_B_DETECT_ALLOW] ? tx_detect_i : 1'b1;
    // polarity 1: high when signal present; 0: high when no signal
    wire nosig_raw   = pin_func[TLPC_B_NOSIG_INV] ? signal_detect_i : ~signal_detect_i;
    wire next_pin39  = pin_func[TLPC_B_ANALOG_SEL] ? analog_out_i : fault_drv;
    wire next_pin21  = pin_func[TLPC_B_DETECT_SEL] ? detect_drv : fault_drv;
    wire next_nosig  = quiet[TLPC_B_NOSIG_INHIB] ? 1'b1 : nosig_raw;
    wire laser_on    = ~quiet[TLPC_B_LASER_INHIB];

    // registered pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin39_o            <= 1'b0;
            pin21_o            <= 1'b0;
            nosig_pin_o        <= 1'b1;
            pd_ctrl_o          <= 1'b0;
            pd_ctrl_oe_o       <= 1'b0;
            tx_data_en_o       <= 1'b0;
            laser_current_en_o <= 1'b0;
            soft_tx_fault_o    <= 1'b0;
            tx_disable_eff_o   <= 1'b0;
        end else begin
            pin39_o            <= next_pin39;
            pin21_o            <= next_pin21;
            nosig_pin_o        <= next_nosig;
            pd_ctrl_o          <= pd_ctrl_i;
            pd_ctrl_oe_o       <= ~quiet[TLPC_B_PD_INHIBIT];
            tx_data_en_o       <= laser_on;
            laser_current_en_o <= laser_on;
            soft_tx_fault_o    <= inj_fault[TLPC_B_SOFT_FAULT];
            tx_disable_eff_o   <= dis_sync ^ pin_func[TLPC_B_TXDIS_INV];
        end
    end

endmodule : tlpc_top

// *** include/tlpc_pkg.sv ***
//======================================================================
//======================================================================
package tlpc_pkg;

    //==================================================================
    // register offsets
    localparam logic [7:0] TLPC_OFF_TEMP_CFG  = 8'hB6;
    localparam logic [7:0] TLPC_OFF_LOOP_CFG  = 8'hB7;
    localparam logic [7:0] TLPC_OFF_LP_CFG    = 8'hB8;
    localparam logic [7:0] TLPC_OFF_TRIM      = 8'hB9;
    localparam logic [7:0] TLPC_OFF_RXP_THR   = 8'hBA;
    localparam logic [7:0] TLPC_OFF_PIN_FUNC  = 8'hBE;
    localparam logic [7:0] TLPC_OFF_QUIET     = 8'hBF;
    localparam logic [7:0] TLPC_OFF_INJ_FAULT = 8'hC0;
    localparam logic [7:0] TLPC_OFF_TEMP_PWR  = 8'hC1;

    //==================================================================
    // writable bit masks (bits kept in storage)
    localparam logic [7:0] TLPC_WM_TEMP_CFG  = 8'hE0;
    localparam logic [7:0] TLPC_WM_LOOP_CFG  = 8'hDD;
    localparam logic [7:0] TLPC_WM_LP_CFG    = 8'h11;
    localparam logic [7:0] TLPC_WM_TRIM      = 8'h3F;
    localparam logic [7:0] TLPC_WM_RXP_THR   = 8'hFF;
    localparam logic [7:0] TLPC_WM_PIN_FUNC  = 8'h7F;
    localparam logic [7:0] TLPC_WM_QUIET     = 8'h0F;
    localparam logic [7:0] TLPC_WM_INJ_FAULT = 8'h01;
    localparam logic [7:0] TLPC_WM_TEMP_PWR  = 8'h20;

    //==================================================================
    // reset values
    localparam logic [7:0] TLPC_RST_TEMP_CFG  = 8'h60;
    localparam logic [7:0] TLPC_RST_LOOP_CFG  = 8'hDC;
    localparam logic [7:0] TLPC_RST_LP_CFG    = 8'h00;
    localparam logic [7:0] TLPC_RST_TRIM      = 8'h1F;
    localparam logic [7:0] TLPC_RST_RXP_THR   = 8'hFF;
    localparam logic [7:0] TLPC_RST_PIN_FUNC  = 8'h40;
    localparam logic [7:0] TLPC_RST_QUIET     = 8'h0B;
    localparam logic [7:0] TLPC_RST_INJ_FAULT = 8'h00;
    localparam logic [7:0] TLPC_RST_TEMP_PWR  = 8'h20;

    //==================================================================
    // field positions
    localparam int TLPC_B_EXT_SENSOR   = 7;
    localparam int TLPC_B_POWER_KEEP   = 5;
    localparam int TLPC_B_BIAS_TBL     = 7;
    localparam int TLPC_B_MON_RECALC   = 6;
    localparam int TLPC_B_TRACK_TBL    = 4;
    localparam int TLPC_B_PD_TBL       = 3;
    localparam int TLPC_B_MOD_TBL      = 2;
    localparam int TLPC_B_LOOP_EN      = 0;
    localparam int TLPC_B_RX_FOLLOW    = 4;
    localparam int TLPC_B_TX_FOLLOW    = 0;
    localparam int TLPC_B_ANALOG_SEL   = 6;
    localparam int TLPC_B_DETECT_SEL   = 5;
    localparam int TLPC_B_FAULT_INV    = 4;
    localparam int TLPC_B_NOSIG_INV    = 3;
    localparam int TLPC_B_TXDIS_INV    = 0;
    localparam int TLPC_B_PD_INHIBIT   = 3;
    localparam int TLPC_B_DETECT_ALLOW = 2;
    localparam int TLPC_B_NOSIG_INHIB  = 1;
    localparam int TLPC_B_LASER_INHIB  = 0;
    localparam int TLPC_B_SOFT_FAULT   = 0;
    localparam int TLPC_B_POWER_HOLD   = 5;

    // loop step states
    typedef enum logic [5:0] {
        TLPC_S_IDLE  = 6'b000001,
        TLPC_S_BIAS  = 6'b000010,
        TLPC_S_MOD   = 6'b000100,
        TLPC_S_PD    = 6'b001000,
        TLPC_S_MON   = 6'b010000,
        TLPC_S_DONE  = 6'b100000
    } tlpc_state_t;

    // table load strobes toward the datapath
    typedef struct packed {
        logic bias_load;
        logic mod_load;
        logic pd_load;
        logic mon_recalc;
    } tlpc_loop_req_t;

    // receive power calibration pair
    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] shift;
    } tlpc_cal_pair_t;

    // register access from the two-wire port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tlpc_req_t;

endpackage : tlpc_pkg
